// file: hw/pbs_pkg.sv
package pbs_pkg;

	// ----------------------------------------------------------------
	// clock and memory layout
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int ROW_W = 11;
	localparam logic [10:0] CLIP_BASE = 11'h000;
	localparam logic [10:0] CLIP_ROWS = 11'h004;
	localparam logic [10:0] MSG_BASE = 11'h010;
	localparam logic [10:0] LAST_ROW = 11'h7ff;
	localparam logic [1:0] LAST_CLIP = 2'h3;

	// ----------------------------------------------------------------
	// timing, in milliseconds
	// ----------------------------------------------------------------
	localparam int DEBOUNCE_MS = 20;
	localparam int LONG_PRESS_MS = 3000;
	localparam int DEFAULT_BLINK_PERIOD_ONE_MS = 250;
	localparam int DEFAULT_BLINK_PERIOD_TWO_MS = 250;
	localparam int DEFAULT_BLINK_PERIOD_THREE_MS = 250;
	localparam int DEFAULT_BLINK_PERIOD_FOUR_MS = 250;
	localparam int CLIP_MS_12K = 330;
	localparam int CLIP_MS_8K = 500;
	localparam int CLIP_MS_6K4 = 625;
	localparam int CLIP_MS_5K3 = 750;
	localparam int CLIP_MS_4K = 1000;

	// ----------------------------------------------------------------
	// codes
	// ----------------------------------------------------------------
	localparam logic [2:0] RATE_12K = 3'h0;
	localparam logic [2:0] RATE_8K = 3'h1;
	localparam logic [2:0] RATE_6K4 = 3'h2;
	localparam logic [2:0] RATE_5K3 = 3'h3;
	localparam logic [2:0] CORRUPT_FLASHES = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SHOW = 3'b001,
		ST_REC = 3'b010,
		ST_PLAY = 3'b011,
		ST_ARM = 3'b100
	} pbs_state_t;

	typedef enum logic [2:0] {
		AFT_IDLE = 3'b000,
		AFT_REC = 3'b001,
		AFT_ARM = 3'b010,
		AFT_ENTER = 3'b011,
		AFT_EDIT = 3'b100,
		AFT_LEAVE = 3'b101
	} pbs_after_t;

	function automatic int default_blink_ms(input logic [1:0] c);
		case (c)
			2'h0: return DEFAULT_BLINK_PERIOD_ONE_MS;
			2'h1: return DEFAULT_BLINK_PERIOD_TWO_MS;
			2'h2: return DEFAULT_BLINK_PERIOD_THREE_MS;
			default: return DEFAULT_BLINK_PERIOD_FOUR_MS;
		endcase
	endfunction : default_blink_ms

	function automatic int clip_ms(input logic [2:0] rate);
		case (rate)
			RATE_12K: return CLIP_MS_12K;
			RATE_8K: return CLIP_MS_8K;
			RATE_6K4: return CLIP_MS_6K4;
			RATE_5K3: return CLIP_MS_5K3;
			default: return CLIP_MS_4K;
		endcase
	endfunction : clip_ms

endpackage : pbs_pkg

// file: hw/pbs_debounce.sv
`timescale 1ns/100ps
module pbs_debounce #(
	parameter int CYC = 2500000
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// raw button, low when pressed
	input wire logic button_n,
	// filtered view
	output logic pressed,
	output logic press,
	output logic let_go
);
	logic meta_n;
	logic sync_n;
	logic [31:0] stable;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_n <= 1'b1;
			sync_n <= 1'b1;
		end else begin
			meta_n <= button_n;
			sync_n <= meta_n;
		end
	end

	// level must hold for CYC cycles before it is believed
	always_ff @(posedge clk) begin
		if (reset) begin
			stable <= 32'h0;
			pressed <= 1'b0;
			press <= 1'b0;
			let_go <= 1'b0;
		end else begin
			press <= 1'b0;
			let_go <= 1'b0;
			if (!sync_n == pressed) begin
				stable <= 32'h0;
			end else if (stable == 32'(CYC - 1)) begin
				stable <= 32'h0;
				pressed <= !sync_n;
				press <= !sync_n;
				let_go <= sync_n;
			end else begin
				stable <= stable + 32'h1;
			end
		end
	end
endmodule : pbs_debounce

// file: hw/pbs_sequencer.sv
`timescale 1ns/100ps
// Contract
// - return to power-down after every operation
// - first sixteen rows hold four clips
// - each chime marks its own event kind; the code reuses chime one and chime two across several events
// - clip n flashes LED n times
// - default period, or period bounded by clip
// - long advance press gives one/two flashes; in edit mode the code flashes the selected clip number, one to four
// - capture during hold enters edit at one
// - edit mode records, plays, clears clip
// - advance steps clips, wraps to one
// - no commands while LED indication runs
// - long advance plus capture leaves edit
// - clip length follows sampling rate
// - power-on pointer setup from stored messages
// - record pointer to free row after recording
// - record until capture high or full
// - debounce capture, playback pointer to new message
// - corrupt memory: seven flashes, no action; the code checks this only outside edit mode
// - record start: LED on, or chime one
// - record stop: LED off, or chime two
// - capture ignored during play, clear, advance
// - trigger pulse plays current message once
module pbs_sequencer #(
	parameter int CYC_PER_MS = pbs_pkg::CYC_PER_MS,
	parameter int DEBOUNCE_CYC = pbs_pkg::DEBOUNCE_MS * pbs_pkg::CYC_PER_MS,
	parameter int LONG_PRESS_CYC = pbs_pkg::LONG_PRESS_MS * pbs_pkg::CYC_PER_MS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// push-buttons, low when pressed
	input wire logic capture_button_n,
	input wire logic advance_button_n,
	input wire logic audio_output_trigger_n,
	input wire logic clear_button_n,
	input wire logic passthrough_button_n,
	// storage array status
	input wire logic cma_corrupt,
	input wire logic msg_empty,
	input wire logic at_first_msg,
	input wire logic at_last_msg,
	input wire logic [10:0] next_msg_row,
	input wire logic [10:0] last_msg_row,
	input wire logic [10:0] free_row,
	input wire logic row_done,
	input wire logic mem_full,
	input wire logic play_end,
	input wire logic [3:0] clip_programmed,
	input wire logic [2:0] sample_rate,
	// storage array and analog control
	output logic rec_en,
	output logic play_en,
	output logic [10:0] rec_row,
	output logic [10:0] play_row,
	output logic rec_from_line,
	output logic clip_play,
	output logic [1:0] clip_pick,
	output logic clear_msg,
	output logic clear_clip,
	// status
	output logic led,
	output logic power_down,
	output logic edit_mode
);
	// ----------------------------------------------------------------
	// button conditioning
	// ----------------------------------------------------------------
	logic cap_level, cap_fall;
	logic adv_level, adv_fall, adv_rise;
	logic trig_fall, clr_fall;
	logic pt_meta, pt_sync;

	pbs_debounce #(.CYC(DEBOUNCE_CYC)) u_cap (
		.clk(clk), .reset(reset), .button_n(capture_button_n),
		.pressed(cap_level), .press(cap_fall), .let_go());
	pbs_debounce #(.CYC(DEBOUNCE_CYC)) u_adv (
		.clk(clk), .reset(reset), .button_n(advance_button_n),
		.pressed(adv_level), .press(adv_fall), .let_go(adv_rise));
	pbs_debounce #(.CYC(DEBOUNCE_CYC)) u_trig (
		.clk(clk), .reset(reset), .button_n(audio_output_trigger_n),
		.pressed(), .press(trig_fall), .let_go());
	pbs_debounce #(.CYC(DEBOUNCE_CYC)) u_clr (
		.clk(clk), .reset(reset), .button_n(clear_button_n),
		.pressed(), .press(clr_fall), .let_go());

	// record source follows the passthrough button level
	always_ff @(posedge clk) begin
		if (reset) begin
			pt_meta <= 1'b1;
			pt_sync <= 1'b1;
			rec_from_line <= 1'b0;
		end else begin
			pt_meta <= passthrough_button_n;
			pt_sync <= pt_meta;
			rec_from_line <= !pt_sync;
		end
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pbs_pkg::pbs_state_t state;
	pbs_pkg::pbs_after_t after;
	logic [2:0] show_n;
	logic show_on;
	logic [31:0] show_half, timer, hold_cnt;
	logic adv_long, init_done;
	logic [1:0] sel;
	logic [10:0] rec_start, saved_rec, saved_play;
	logic [31:0] clip_cyc;

	logic go_show, go_rec, go_play, go_arm, go_idle, go_aud;
	logic [2:0] go_n;
	logic [1:0] go_clip;
	pbs_pkg::pbs_after_t go_after;
	logic start_rec, end_rec, fwd_step, next_clip, enter_edit, exit_edit;
	logic clip_req, clr_msg_req, clr_clip_req, corrupt_hit, long_hit, any_ev, show_last;

	assign clip_cyc = 32'(pbs_pkg::clip_ms(sample_rate) * CYC_PER_MS);

	// half of one flash period; a programmed clip bounds the whole indication
	function automatic logic [31:0] half_of(input logic [1:0] c, input logic [2:0] n,
			input logic aud);
		logic [31:0] p;
		logic [1:0] sh;
		sh = (n >= 3'h3) ? 2'h2 : 2'(n - 3'h1);
		p = aud ? (clip_cyc >> sh) : 32'(pbs_pkg::default_blink_ms(c) * CYC_PER_MS);
		p = p >> 1;
		if (p == 32'h0) begin
			p = 32'h1;
		end
		return p;
	endfunction : half_of

	function automatic logic [10:0] clip_row(input logic [1:0] s);
		return 11'(pbs_pkg::CLIP_BASE + 11'(s) * pbs_pkg::CLIP_ROWS);
	endfunction : clip_row

	// next message row, circular over the message area
	function automatic logic [10:0] step_row(input logic [10:0] r);
		return (r == pbs_pkg::LAST_ROW) ? pbs_pkg::MSG_BASE : 11'(r + 11'h1);
	endfunction : step_row

	assign long_hit = (state == pbs_pkg::ST_IDLE) && adv_level && !adv_long
		&& (hold_cnt == 32'(LONG_PRESS_CYC - 1));
	assign any_ev = cap_fall | trig_fall | clr_fall | adv_fall | long_hit;
	assign show_last = (state == pbs_pkg::ST_SHOW) && (timer == 32'h0) && !show_on
		&& (show_n == 3'h1);

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	always_comb begin
		go_show = 1'b0;
		go_rec = 1'b0;
		go_play = 1'b0;
		go_arm = 1'b0;
		go_idle = 1'b0;
		go_aud = 1'b0;
		go_n = 3'h1;
		go_clip = 2'h0;
		go_after = pbs_pkg::AFT_IDLE;
		start_rec = 1'b0;
		end_rec = 1'b0;
		fwd_step = 1'b0;
		next_clip = 1'b0;
		enter_edit = 1'b0;
		exit_edit = 1'b0;
		clip_req = 1'b0;
		clr_msg_req = 1'b0;
		clr_clip_req = 1'b0;
		corrupt_hit = 1'b0;
		case (state)
			pbs_pkg::ST_IDLE: begin
				if (any_ev && cma_corrupt && !edit_mode) begin
					corrupt_hit = 1'b1;
					go_show = 1'b1;
					go_n = pbs_pkg::CORRUPT_FLASHES;
				end else if (cap_fall && !adv_level) begin
					if (edit_mode || !clip_programmed[0]) begin
						go_rec = 1'b1;
						start_rec = 1'b1;
					end else begin
						go_show = 1'b1;
						go_aud = 1'b1;
						go_after = pbs_pkg::AFT_REC;
					end
				end else if (trig_fall) begin
					if (edit_mode) begin
						clip_req = 1'b1;
					end else begin
						go_play = 1'b1;
					end
				end else if (clr_fall) begin
					if (edit_mode) begin
						clr_clip_req = 1'b1;
					end else if (at_first_msg || at_last_msg) begin
						clr_msg_req = 1'b1;
						go_show = 1'b1;
						go_aud = 1'b1;
						go_n = 3'h2;
						go_clip = 2'h1;
					end else begin
						go_show = 1'b1;
						go_aud = 1'b1;
						go_n = 3'h3;
						go_clip = 2'h2;
					end
				end else if (long_hit) begin
					go_show = 1'b1;
					go_aud = 1'b1;
					go_after = pbs_pkg::AFT_ARM;
					if (edit_mode) begin
						go_n = 3'({1'b0, sel} + 3'h1);
						go_clip = sel;
					end else if (at_last_msg || msg_empty) begin
						go_n = 3'h2;
						go_clip = 2'h1;
					end
				end else if (adv_rise && !adv_long) begin
					go_show = 1'b1;
					if (edit_mode) begin
						next_clip = 1'b1;
						go_clip = 2'(sel + 2'h1);
						go_n = (sel == pbs_pkg::LAST_CLIP) ? 3'h1 : 3'({1'b0, sel} + 3'h2);
					end else begin
						fwd_step = 1'b1;
						go_aud = 1'b1;
						if (at_last_msg) begin
							go_n = 3'h2;
							go_clip = 2'h1;
						end
					end
				end
			end
			pbs_pkg::ST_ARM: begin
				if (!adv_level) begin
					go_idle = 1'b1;
				end else if (cap_fall) begin
					go_show = 1'b1;
					if (edit_mode) begin
						go_n = 3'h2;
						go_clip = 2'h1;
						go_aud = 1'b1;
						go_after = pbs_pkg::AFT_LEAVE;
					end else begin
						go_after = pbs_pkg::AFT_ENTER;
					end
				end
			end
			pbs_pkg::ST_REC: begin
				if (!cap_level || mem_full) begin
					end_rec = 1'b1;
					if (!edit_mode && clip_programmed[1]) begin
						go_show = 1'b1;
						go_aud = 1'b1;
						go_n = 3'h2;
						go_clip = 2'h1;
					end else begin
						go_idle = 1'b1;
					end
				end
			end
			pbs_pkg::ST_PLAY: begin
				if (play_end || trig_fall) begin
					go_idle = 1'b1;
				end
			end
			pbs_pkg::ST_SHOW: begin
				if (show_last) begin
					case (after)
						pbs_pkg::AFT_REC: begin
							go_rec = 1'b1;
							start_rec = 1'b1;
						end
						pbs_pkg::AFT_ARM: go_arm = 1'b1;
						pbs_pkg::AFT_ENTER: begin
							go_show = 1'b1;
							go_after = pbs_pkg::AFT_EDIT;
						end
						pbs_pkg::AFT_EDIT: begin
							enter_edit = 1'b1;
							go_idle = 1'b1;
						end
						pbs_pkg::AFT_LEAVE: begin
							exit_edit = 1'b1;
							go_idle = 1'b1;
						end
						default: go_idle = 1'b1;
					endcase
				end
			end
			default: go_idle = 1'b1;
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer and indication timing
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= pbs_pkg::ST_IDLE;
			after <= pbs_pkg::AFT_IDLE;
			show_n <= 3'h0;
			show_on <= 1'b0;
			show_half <= 32'h1;
			timer <= 32'h0;
		end else if (go_show) begin
			state <= pbs_pkg::ST_SHOW;
			after <= go_after;
			show_n <= go_n;
			show_on <= 1'b1;
			show_half <= half_of(go_clip, go_n, go_aud & clip_programmed[go_clip]);
			timer <= half_of(go_clip, go_n, go_aud & clip_programmed[go_clip]);
		end else if (go_rec) begin
			state <= pbs_pkg::ST_REC;
		end else if (go_play) begin
			state <= pbs_pkg::ST_PLAY;
		end else if (go_arm) begin
			state <= pbs_pkg::ST_ARM;
		end else if (go_idle) begin
			state <= pbs_pkg::ST_IDLE;
		end else if (state == pbs_pkg::ST_SHOW) begin
			if (timer != 32'h0) begin
				timer <= timer - 32'h1;
			end else if (show_on) begin
				show_on <= 1'b0;
				timer <= show_half;
			end else begin
				show_n <= show_n - 3'h1;
				show_on <= 1'b1;
				timer <= show_half;
			end
		end
	end

	// long advance press detection
	always_ff @(posedge clk) begin
		if (reset) begin
			hold_cnt <= 32'h0;
			adv_long <= 1'b0;
		end else if (!adv_level) begin
			hold_cnt <= 32'h0;
			adv_long <= 1'b0;
		end else if (long_hit) begin
			adv_long <= 1'b1;
		end else if (state == pbs_pkg::ST_IDLE && !adv_long) begin
			hold_cnt <= hold_cnt + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// pointers and edit selection
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			init_done <= 1'b0;
			rec_row <= pbs_pkg::MSG_BASE;
			play_row <= pbs_pkg::MSG_BASE;
			rec_start <= pbs_pkg::MSG_BASE;
			saved_rec <= pbs_pkg::MSG_BASE;
			saved_play <= pbs_pkg::MSG_BASE;
			edit_mode <= 1'b0;
			sel <= 2'h0;
		end else if (!init_done) begin
			init_done <= 1'b1;
			rec_row <= msg_empty ? pbs_pkg::MSG_BASE : free_row;
			play_row <= msg_empty ? pbs_pkg::MSG_BASE : last_msg_row;
		end else if (start_rec) begin
			rec_start <= rec_row;
		end else if (state == pbs_pkg::ST_REC && row_done && !end_rec) begin
			if (edit_mode) begin
				rec_row <= {rec_row[10:2], 2'(rec_row[1:0] + 2'h1)};
			end else begin
				rec_row <= step_row(rec_row);
			end
		end else if (end_rec) begin
			if (edit_mode) begin
				rec_row <= clip_row(sel);
			end else begin
				play_row <= rec_start;
				// a row finished in the stop cycle still counts
				if (row_done) begin
					rec_row <= step_row(rec_row);
				end
			end
		end else if (fwd_step) begin
			play_row <= next_msg_row;
		end else if (enter_edit) begin
			edit_mode <= 1'b1;
			sel <= 2'h0;
			saved_rec <= rec_row;
			saved_play <= play_row;
			rec_row <= clip_row(2'h0);
			play_row <= clip_row(2'h0);
		end else if (next_clip) begin
			sel <= 2'(sel + 2'h1);
			rec_row <= clip_row(2'(sel + 2'h1));
			play_row <= clip_row(2'(sel + 2'h1));
		end else if (exit_edit) begin
			edit_mode <= 1'b0;
			rec_row <= saved_rec;
			play_row <= saved_play;
		end
	end

	// one-cycle requests to the array
	always_ff @(posedge clk) begin
		if (reset) begin
			clip_play <= 1'b0;
			clip_pick <= 2'h0;
			clear_msg <= 1'b0;
			clear_clip <= 1'b0;
		end else begin
			clip_play <= (go_show && go_aud && clip_programmed[go_clip]) || clip_req;
			clip_pick <= go_show ? go_clip : (clip_req ? sel : clip_pick);
			clear_msg <= clr_msg_req;
			clear_clip <= clr_clip_req;
		end
	end

	assign rec_en = (state == pbs_pkg::ST_REC);
	assign play_en = (state == pbs_pkg::ST_PLAY);
	assign led = rec_en || play_en || (state == pbs_pkg::ST_SHOW && show_on);
	assign power_down = (state == pbs_pkg::ST_IDLE);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_idle_after_show: assert property (@(posedge clk) disable iff (reset)
		(show_last && after == pbs_pkg::AFT_IDLE) |=> power_down)
		else $error("no power-down after indication");
	chk_busy_no_cmd: assert property (@(posedge clk) disable iff (reset)
		(state == pbs_pkg::ST_SHOW && !show_last) |=> (!clear_msg && !clear_clip && !rec_en))
		else $error("command accepted during indication");
	chk_power_on_ptr: assert property (@(posedge clk) disable iff (reset)
		(!init_done && msg_empty) |=> (rec_row == pbs_pkg::MSG_BASE
			&& play_row == pbs_pkg::MSG_BASE))
		else $error("pointers not at memory start");
	chk_play_new_msg: assert property (@(posedge clk) disable iff (reset)
		(end_rec && !edit_mode) |=> (play_row == $past(rec_start)))
		else $error("playback pointer not at new message");
	chk_full_stops: assert property (@(posedge clk) disable iff (reset)
		(rec_en && mem_full) |=> !rec_en)
		else $error("recording past full memory");
	chk_corrupt_seven: assert property (@(posedge clk) disable iff (reset)
		corrupt_hit |=> (led && show_n == 3'h7 && !rec_en && !play_en) ##1 led)
		else $error("corrupt memory not flagged");
	chk_clip_rows: assert property (@(posedge clk) disable iff (reset)
		edit_mode |-> (rec_row < pbs_pkg::MSG_BASE && play_row < pbs_pkg::MSG_BASE))
		else $error("clip pointer outside reserved rows");
	chk_cap_in_play: assert property (@(posedge clk) disable iff (reset)
		(play_en && cap_fall) |=> !rec_en)
		else $error("capture accepted during playback");
	chk_clip_wrap: assert property (@(posedge clk) disable iff (reset)
		(next_clip && sel == pbs_pkg::LAST_CLIP) |=> (sel == 2'h0 && show_n == 3'h1))
		else $error("clip selection did not wrap");
	chk_fwd_ptr: assert property (@(posedge clk) disable iff (reset)
		fwd_step |=> (play_row == $past(next_msg_row)))
		else $error("advance did not move playback pointer");

	cov_enter_edit: cover property (@(posedge clk) disable iff (reset) enter_edit);
	cov_leave_edit: cover property (@(posedge clk) disable iff (reset) exit_edit);
	cov_record_done: cover property (@(posedge clk) disable iff (reset) end_rec && !edit_mode);
	cov_corrupt: cover property (@(posedge clk) disable iff (reset) corrupt_hit);
endmodule : pbs_sequencer

// file: testbench/pbs_store_model.sv
`timescale 1ns/100ps
module pbs_store_model #(
	parameter int FULL_ROWS = 6,
	parameter int ROW_CYC = 8,
	parameter int PLAY_CYC = 100
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// sequencer control
	input wire logic rec_en,
	input wire logic play_en,
	// array status
	output logic row_done,
	output logic mem_full,
	output logic play_end,
	output int rows
);
	int cnt;

	assign mem_full = rows >= FULL_ROWS;
	assign row_done = rec_en && !mem_full && cnt == ROW_CYC - 1;
	assign play_end = play_en && cnt == PLAY_CYC - 1;

	always_ff @(posedge clk) begin
		if (reset || !(rec_en || play_en) || row_done) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rows <= 0;
		end else if (row_done) begin
			rows <= rows + 1;
		end
	end
endmodule : pbs_store_model

// file: testbench/pbs_sequencer_tb.sv
`timescale 1ns/100ps
module pbs_sequencer_tb;
	localparam int CPM = 10;
	typedef struct {int b; logic l, f, c; logic [3:0] p; int fl; logic [1:0] ev;} pbs_row_t;
	pbs_row_t tab[6] = '{
		'{1, 0, 0, 0, 4'h0, 1, 2'b00},
		'{1, 1, 0, 0, 4'h0, 2, 2'b00},
		'{1, 0, 0, 0, 4'h1, 1, 2'b01},
		'{3, 0, 1, 0, 4'h0, 2, 2'b10},
		'{3, 0, 0, 0, 4'h0, 3, 2'b00},
		'{1, 0, 0, 1, 4'h0, 7, 2'b00}
	};
	logic clk, reset, corrupt, empty, first, last, pl;
	logic [3:0] btn, prog;
	logic [10:0] rec_row, play_row, nrow, frow, lrow, r0;
	logic row_done, mem_full, play_end, rec_en, play_en, clip_play, clear_msg;
	logic led, power_down, edit_mode;
	logic [2:0] mid;
	logic [2:0] seen;
	logic [1:0] pick;
	logic pt_n, line, clear_clip;
	int rows, num_errors, compares, n, w, k, ew;

	pbs_sequencer #(.CYC_PER_MS(CPM), .DEBOUNCE_CYC(4), .LONG_PRESS_CYC(200)) dut (
		.clk(clk), .reset(reset),
		.capture_button_n(btn[0]), .advance_button_n(btn[1]),
		.audio_output_trigger_n(btn[2]), .clear_button_n(btn[3]),
		.passthrough_button_n(pt_n), .cma_corrupt(corrupt), .msg_empty(empty),
		.at_first_msg(first), .at_last_msg(last), .next_msg_row(nrow),
		.last_msg_row(lrow), .free_row(frow), .row_done(row_done), .mem_full(mem_full),
		.play_end(play_end), .clip_programmed(prog), .sample_rate(3'h0),
		.rec_en(rec_en), .play_en(play_en), .rec_row(rec_row), .play_row(play_row),
		.rec_from_line(line), .clip_play(clip_play), .clip_pick(pick), .clear_msg(clear_msg),
		.clear_clip(clear_clip), .led(led), .power_down(power_down), .edit_mode(edit_mode)
	);

	pbs_store_model stor (
		.clk(clk), .reset(reset), .rec_en(rec_en), .play_en(play_en),
		.row_done(row_done), .mem_full(mem_full), .play_end(play_end), .rows(rows)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	task automatic chk(input bit ok, input string msg);
		compares++;
		if (!ok) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask : chk

	task automatic wrap_up;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic do_reset;
		reset = 1'b1;
		repeat (4) tick;
		reset = 1'b0;
		tick;
		tick;
	endtask : do_reset

	// press button b for hold cycles, count flashes until idle
	task automatic op(input int b, input int hold);
		n = 0;
		w = 0;
		k = 0;
		pl = 1'b0;
		seen = 3'b000;
		btn[b] = 1'b0;
		for (int c = 0; c < 30000; c++) begin
			tick;
			if (c == hold) btn[b] = 1'b1;
			if (c == hold - 1) mid = {rec_en, led, play_en};
			if (led === 1'b1 && !pl) n++;
			if (led === 1'b1) k++;
			else if (pl && w == 0) w = k;
			seen = seen | {clear_clip === 1'b1, clear_msg === 1'b1, clip_play === 1'b1};
			pl = (led === 1'b1);
			if (c > hold + 20 && power_down === 1'b1 && led === 1'b0) break;
		end
	endtask : op

	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		wrap_up;
	end

	initial begin
		{reset, corrupt, empty, first, last} = 5'h10;
		btn = 4'hf;
		pt_n = 1'b1;
		prog = 4'h0;
		nrow = 11'h200;
		frow = 11'h123;
		lrow = 11'h100;
		do_reset;
		chk(rec_row === frow && play_row === lrow, "pointers after reset");
		foreach (tab[i]) begin
			{last, first, corrupt, prog} = {tab[i].l, tab[i].f, tab[i].c, tab[i].p};
			nrow = 11'h200 + 11'(i);
			r0 = (tab[i].b == 1 && !tab[i].c) ? nrow : play_row;
			ew = (tab[i].p[0] ? pbs_pkg::CLIP_MS_12K : pbs_pkg::DEFAULT_BLINK_PERIOD_ONE_MS);
			ew = ew * CPM / 2 + 1;
			op(tab[i].b, 20);
			chk(n == tab[i].fl, "flash count");
			chk(w == ew, "flash width");
			chk(seen === {1'b0, tab[i].ev}, "clip or clear pulse");
			chk(play_row === r0, "playback pointer");
			chk(power_down === 1'b1, "idle after op");
		end
		{corrupt, prog, last} = 6'h00;
		$display("done: table");
		empty = 1'b1;
		do_reset;
		chk(rec_row === pbs_pkg::MSG_BASE && play_row === pbs_pkg::MSG_BASE, "empty");
		op(0, 40);
		chk(mid === 3'b110, "recording led on");
		chk(rec_en === 1'b0 && led === 1'b0 && power_down === 1'b1, "stop");
		chk(play_row === pbs_pkg::MSG_BASE, "playback at new message");
		chk(rows > 0 && rec_row === pbs_pkg::MSG_BASE + 11'(rows), "free row");
		empty = 1'b0;
		$display("done: record");
		r0 = play_row;
		btn[2] = 1'b0;
		repeat (20) tick;
		btn[2] = 1'b1;
		chk(play_en === 1'b1, "play started");
		repeat (10) tick;
		btn[0] = 1'b0;
		pl = 1'b1;
		repeat (40) begin
			tick;
			if (rec_en !== 1'b0) pl = 1'b0;
		end
		btn[0] = 1'b1;
		chk(pl, "capture during play ignored");
		for (k = 0; k < 300 && power_down !== 1'b1; k++) tick;
		chk(play_en === 1'b0 && play_row === r0, "play ended");
		$display("done: play");
		r0 = rec_row;
		op(0, 200);
		chk(mid[2] === 1'b0, "full stops recording");
		chk(rec_row === pbs_pkg::MSG_BASE + 11'h006 && play_row === r0, "full");
		$display("done: full");
		do_reset;
		btn[1] = 1'b0;
		n = 0;
		pl = 1'b0;
		for (k = 0; k < 2800; k++) begin
			tick;
			if (led === 1'b1 && !pl) n++;
			pl = (led === 1'b1);
		end
		chk(n == 1, "long press flash");
		btn[0] = 1'b0;
		for (k = 0; k < 9000 && edit_mode !== 1'b1; k++) tick;
		chk(edit_mode === 1'b1 && rec_row === pbs_pkg::CLIP_BASE, "edit entry");
		btn = 4'hf;
		repeat (20) tick;
		for (k = 0; k < 9000 && !(power_down === 1'b1 && led === 1'b0); k++) tick;
		r0 = rec_row;
		op(1, 20);
		chk(rec_row === ((r0 + 11'h004) & 11'h00f), "next clip");
		chk(n == (r0[3:2] == 2'h3 ? 1 : r0[3:2] + 2), "clip flashes");
		op(2, 20);
		chk(n == 0 && seen === 3'b001 && pick === 2'h1, "clip play in edit");
		op(3, 20);
		r0 = pbs_pkg::CLIP_BASE + pbs_pkg::CLIP_ROWS;
		chk(n == 0 && seen === 3'b100 && rec_row === r0, "clip clear in edit");
		pt_n = 1'b0;
		repeat (3) tick;
		chk(line === 1'b1, "line input source");
		pt_n = 1'b1;
		btn[1] = 1'b0;
		repeat (6000) tick;
		btn[0] = 1'b0;
		for (k = 0; k < 9000 && edit_mode !== 1'b0; k++) tick;
		chk(edit_mode === 1'b0 && rec_row === frow && play_row === lrow, "edit exit");
		btn = 4'hf;
		repeat (20) tick;
		$display("done: edit");
		wrap_up;
	end
endmodule : pbs_sequencer_tb
